// [common/cra_pkg.sv]
// Shared types and constants for the cell register asynchronous control block
package cra_pkg;

   // ==========================================================
   // Asynchronous control modes of one cell register
   // ==========================================================
   typedef enum logic [2:0]
   {
      CRA_CLEAR_ONLY,    // Either cluster line clears
      CRA_PRESET_LOAD,   // First line loads a tied-high one
      CRA_PRESET_INV,    // First line presets through inverted clear
      CRA_PRESET_CLEAR,  // First line presets, second line clears
      CRA_LOAD_CLEAR,    // First line loads third input, second clears
      CRA_LOAD_PRESET,   // Inverted register, first loads, second presets
      CRA_LOAD_ONLY,     // First line loads third input
      CRA_NO_ASYNC       // Plain synchronous flip-flop
   } cra_mode_t;

   // ==========================================================
   // Carriers
   // ==========================================================
   // Shared cluster lines plus the cell's third data input
   typedef struct packed
   {
      logic cluster_ctl_first;
      logic cluster_ctl_second;
      logic cell_third_input;
   } cra_ctl_t;

   // Physical controls of the storage flop
   typedef struct packed
   {
      logic pre;   // Async force to one
      logic clr;   // Async force to zero, wins over pre
   } cra_async_t;

   // ==========================================================
   // Constants
   // ==========================================================
   localparam logic CRA_RESET_Q   = 1'h0;  // Physical value after clear or reset
   localparam logic CRA_TIED_HIGH = 1'h1;  // Physical value after preset

endpackage

// [src/cra_async_flop.sv]
// Storage flop with asynchronous clear, preset and clock enable
`timescale 1ns/10ps
module cra_async_flop
   import cra_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire cra_async_t async_ctl,
   input  wire logic       d,
   input  wire logic       ena,
   output logic            q
);

   // ==========================================================
   // Local copies of the asynchronous controls
   // ==========================================================
   logic phys_pre;   // Effective preset, only while clear and reset are off
   logic phys_clr;   // Async clear request
   logic q_ff;       // Stored bit
   logic nxt_q;      // Next stored bit on a clock edge

   // Preset gated by clear and reset, so dropping the clear while a preset
   // is still held gives a rising edge here and the preset acts at once
   // rather than waiting for the next clock edge
   assign phys_pre = async_ctl.pre & ~async_ctl.clr & ~reset;
   assign phys_clr = async_ctl.clr;

   // ==========================================================
   // Next value: hold unless enabled
   // ==========================================================
   always_comb
   begin
      nxt_q = q_ff;
      if (ena)
      begin
         nxt_q = d;   // Ordinary capture
      end
   end

   // ==========================================================
   // Register with asynchronous controls
   // ==========================================================
   // Clear beats preset so a clash always settles to zero
   always_ff @(posedge clk or posedge reset or posedge phys_clr or posedge phys_pre)
   begin
      if (reset || phys_clr)
      begin
         q_ff <= CRA_RESET_Q;   // Clear outranks preset
      end
      else if (phys_pre)
      begin
         q_ff <= CRA_TIED_HIGH;
      end
      else
      begin
         q_ff <= nxt_q;   // Clocked capture, nothing forcing
      end
   end

   assign q = q_ff;

endmodule

// [src/cra_cell_register.sv]
// Cell register with shared cluster lines steering asynchronous preset and clear
`timescale 1ns/10ps
module cra_cell_register
   import cra_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      reset,
   input  wire cra_mode_t cell_mode,
   input  wire cra_ctl_t  cluster_ctl,
   input  wire logic      sync_data,
   input  wire logic      sync_ena,
   output logic           cell_q,
   output logic           third_free
);

   // ==========================================================
   // Declarations
   // ==========================================================
   logic       ctl_first;    // First shared cluster line
   logic       ctl_second;   // Second shared cluster line
   logic       ctl_third;    // Third data input of the cell
   cra_async_t phys_ctl;     // Controls seen by the storage flop
   logic       phys_inv;     // Register kept inverted at both ends
   logic       phys_d;       // Data into the storage flop
   logic       phys_q;       // Data out of the storage flop
   logic       async_hit;    // Any asynchronous control active

   assign ctl_first  = cluster_ctl.cluster_ctl_first;
   assign ctl_second = cluster_ctl.cluster_ctl_second;
   assign ctl_third  = cluster_ctl.cell_third_input;

   // ==========================================================
   // Mode decode onto physical preset and clear
   // ==========================================================
   // Loads are never a data path into the flop: they steer preset or
   // clear from the load value, so the flop only ever forces constants.
   always_comb
   begin
      phys_ctl   = '0;
      phys_inv   = 1'h0;
      third_free = 1'h0;
      unique case (cell_mode)
         CRA_CLEAR_ONLY:
         begin
            // Preset held inactive, either line clears
            phys_ctl.clr = ctl_first | ctl_second;
            third_free   = 1'h1;
         end
         CRA_PRESET_LOAD:
         begin
            // Load value tied high inside the cell, so load means one
            phys_ctl.pre = ctl_first & CRA_TIED_HIGH;
         end
         CRA_PRESET_INV:
         begin
            // Clear of an inverted register reads back as one
            phys_inv     = 1'h1;
            phys_ctl.clr = ctl_first;
            third_free   = 1'h1;
         end
         CRA_PRESET_CLEAR:
         begin
            // Tied-high load presets, second line clears
            phys_ctl.pre = ctl_first & CRA_TIED_HIGH;
            phys_ctl.clr = ctl_second;
         end
         CRA_LOAD_CLEAR:
         begin
            // Second line feeds the clear path only
            phys_ctl.pre = ctl_first & ctl_third;
            phys_ctl.clr = (ctl_first & ~ctl_third) | ctl_second;
         end
         CRA_LOAD_PRESET:
         begin
            // Load value driven inverted to match the inverted output
            phys_inv     = 1'h1;
            phys_ctl.pre = ctl_first & ~ctl_third;
            phys_ctl.clr = (ctl_first & ctl_third) | ctl_second;
         end
         CRA_LOAD_ONLY:
         begin
            // Load value picks preset or clear
            phys_ctl.pre = ctl_first & ctl_third;
            phys_ctl.clr = ctl_first & ~ctl_third;
         end
         CRA_NO_ASYNC:
         begin
            // Nothing asynchronous, third input unused here
            third_free = 1'h1;
         end
      endcase
   end

   // ==========================================================
   // Inversion around the storage flop
   // ==========================================================
   // Hazard: chip reset clears the flop, so inverted modes read one
   assign phys_d    = sync_data ^ phys_inv;
   assign cell_q    = phys_q ^ phys_inv;
   assign async_hit = phys_ctl.pre | phys_ctl.clr;

   // ==========================================================
   // Storage flop
   // ==========================================================
   // Clear outranks preset inside the flop
   // Enabled capture when no control is active
   cra_async_flop u_flop
   (
      .clk       (clk),
      .reset     (reset),
      .async_ctl (phys_ctl),
      .d         (phys_d),
      .ena       (sync_ena),
      .q         (phys_q)
   );

   // ==========================================================
   // Checks
   // ==========================================================
   // Controls are sampled at the clock; async effects are settled by then
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_clear_only;
      (cell_mode == CRA_CLEAR_ONLY) && (ctl_first || ctl_second)
         |-> (cell_q == 1'h0) && !phys_ctl.pre;
   endproperty
   a_clear_only: assert property (p_clear_only)
      else $error("clear-only mode did not clear");

   property p_preset_load;
      (cell_mode == CRA_PRESET_LOAD) && ctl_first |-> cell_q == 1'h1;
   endproperty
   a_preset_load: assert property (p_preset_load)
      else $error("tied-high load did not preset");

   property p_preset_inv;
      (cell_mode == CRA_PRESET_INV) && ctl_first
         |-> (cell_q == 1'h1) && (phys_q == 1'h0);
   endproperty
   a_preset_inv: assert property (p_preset_inv)
      else $error("inverted clear did not read as one");

   sequence s_inv_capture;
      (cell_mode == CRA_PRESET_INV) && !ctl_first && sync_ena
         ##1 (cell_mode == CRA_PRESET_INV) && !ctl_first;
   endsequence
   property p_third_free;
      s_inv_capture |-> (cell_q == $past(sync_data)) && third_free;
   endproperty
   a_third_free: assert property (p_third_free)
      else $error("inverted preset mode misused the third input");

   property p_preset_clear;
      (cell_mode == CRA_PRESET_CLEAR) && (ctl_first || ctl_second)
         |-> cell_q == !ctl_second;
   endproperty
   a_preset_clear: assert property (p_preset_clear)
      else $error("preset and clear gave wrong value");

   property p_load_clear;
      (cell_mode == CRA_LOAD_CLEAR) && (ctl_first || ctl_second)
         |-> cell_q == (ctl_third && !ctl_second);
   endproperty
   a_load_clear: assert property (p_load_clear)
      else $error("load with clear gave wrong value");

   property p_load_preset;
      (cell_mode == CRA_LOAD_PRESET) && (ctl_first || ctl_second)
         |-> cell_q == (ctl_second || ctl_third);
   endproperty
   a_load_preset: assert property (p_load_preset)
      else $error("load with preset gave wrong value");

   property p_load_only;
      (cell_mode == CRA_LOAD_ONLY) && ctl_first |-> cell_q == ctl_third;
   endproperty
   a_load_only: assert property (p_load_only)
      else $error("load-only did not take the third input");

   sequence s_clash;
      ((cell_mode == CRA_PRESET_CLEAR) || (cell_mode == CRA_LOAD_CLEAR))
         && ctl_first && ctl_second && ctl_third;
   endsequence
   property p_clear_wins;
      s_clash [*2] |-> (cell_q == 1'h0) && $stable(cell_q);
   endproperty
   a_clear_wins: assert property (p_clear_wins)
      else $error("load or preset beat a clear");

   sequence s_idle_capture;
      !async_hit && sync_ena ##1 !async_hit && $stable(cell_mode);
   endsequence
   property p_sync_capture;
      s_idle_capture |-> cell_q == $past(sync_data);
   endproperty
   a_sync_capture: assert property (p_sync_capture)
      else $error("enabled clock edge did not capture data");

   property p_hold;
      !async_hit && !sync_ena ##1 !async_hit && $stable(cell_mode)
         |-> $stable(cell_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("register changed without enable");

endmodule

// [verif/testbench.sv]
// Self-checking bench for the cell register asynchronous control block
`timescale 1ns/10ps
module testbench
   import cra_pkg::*;
;
   // ==========================================================
   // Signals
   // ==========================================================
   logic       clk;          // Bench clock, 100 ns period
   logic       reset;        // Async reset, active high
   cra_mode_t  cell_mode;    // Static mode under test
   cra_ctl_t   cluster_ctl;  // Cluster lines and third input
   logic       sync_data;    // Synchronous data
   logic       sync_ena;     // Clock enable
   logic       cell_q;       // Logical register output
   logic       third_free;   // Third input unused flag
   integer     num_errors;   // Mismatches seen
   integer     check_count;  // Comparisons made
   integer     mq;           // Model of the logical output
   integer     m;            // Mode loop index
   logic [1:0] frc;          // Model force flag and value

   // ==========================================================
   // Design under test
   // ==========================================================
   cra_cell_register cra_cell_register_i
   (
      .clk         (clk),
      .reset       (reset),
      .cell_mode   (cell_mode),
      .cluster_ctl (cluster_ctl),
      .sync_data   (sync_data),
      .sync_ena    (sync_ena),
      .cell_q      (cell_q),
      .third_free  (third_free)
   );

   // ==========================================================
   // Clock
   // ==========================================================
   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // ==========================================================
   // Reference model
   // ==========================================================
   // Logical forced value; clear-like lines tested first so they win
   function automatic logic [1:0] force_of(cra_mode_t md, cra_ctl_t c);
      case (md)
         CRA_CLEAR_ONLY:   return (c.cluster_ctl_first | c.cluster_ctl_second) ? 2'h2 : 2'h0;
         CRA_PRESET_LOAD,
         CRA_PRESET_INV:   return c.cluster_ctl_first ? 2'h3 : 2'h0;
         CRA_PRESET_CLEAR: return c.cluster_ctl_second ? 2'h2 :
                                  (c.cluster_ctl_first ? 2'h3 : 2'h0);
         CRA_LOAD_CLEAR:   return c.cluster_ctl_second ? 2'h2 :
                                  (c.cluster_ctl_first ? {1'h1, c.cell_third_input} : 2'h0);
         CRA_LOAD_PRESET:  return c.cluster_ctl_second ? 2'h3 :
                                  (c.cluster_ctl_first ? {1'h1, c.cell_third_input} : 2'h0);
         CRA_LOAD_ONLY:    return c.cluster_ctl_first ? {1'h1, c.cell_third_input} : 2'h0;
         default:          return 2'h0;
      endcase
   endfunction

   // ==========================================================
   // Checking and closing
   // ==========================================================
   task automatic check(input string name, input logic seen, input logic exp);
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
      end
   endtask

   task automatic complete_run;
      if (num_errors == 0 && check_count > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One clock of stimulus with the model stepped alongside
   task automatic drive_step(input cra_ctl_t c, input logic d, input logic e);
      @(posedge clk);
      // Capture only when no control forces the flop
      frc = force_of(cell_mode, cluster_ctl);
      if (!frc[1] && sync_ena)
      begin
         mq = sync_data;
      end
      #5;
      cluster_ctl = c;
      sync_data   = d;
      sync_ena    = e;
      #45;
      frc = force_of(cell_mode, cluster_ctl);
      if (frc[1])
      begin
         mq = frc[0];
      end
      check("cell_q", cell_q, mq[0]);
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   // Every mode is entered under reset, so inverted modes start clean
   initial
   begin
      reset       = 1'h1;
      cell_mode   = CRA_NO_ASYNC;
      cluster_ctl = '0;
      sync_data   = 1'h0;
      sync_ena    = 1'h0;
      num_errors  = 0;
      check_count = 0;
      mq          = 0;
      void'($urandom(32'he61a));
      repeat (4) @(posedge clk);
      for (m = 0; m < 8; m = m + 1)
      begin
         @(posedge clk);
         #5;
         reset       = 1'h1;
         cell_mode   = cra_mode_t'(m[2:0]);
         cluster_ctl = '0;
         // Physical clear reads back as one in inverted modes
         mq = (cell_mode == CRA_PRESET_INV || cell_mode == CRA_LOAD_PRESET) ? 1 : 0;
         #45;
         check("reset_q", cell_q, mq[0]);
         check("third_free", third_free, (cell_mode == CRA_CLEAR_ONLY) ||
               (cell_mode == CRA_PRESET_INV) || (cell_mode == CRA_NO_ASYNC));
         @(posedge clk);
         #5;
         reset = 1'h0;
         repeat (60)
         begin
            // Sparse line activity leaves room for clocked captures
            drive_step({($urandom % 4 == 0), ($urandom % 5 == 0), 1'($urandom)},
                       1'($urandom), ($urandom % 4 != 0));
         end
         // Held clash, then the clear dropped while the load is still held
         repeat (3) drive_step(3'h7, 1'h1, 1'h1);
         drive_step(3'h5, 1'h0, 1'h1);
         repeat (3) drive_step(3'h6, 1'h1, 1'h1);
         drive_step(3'h4, 1'h1, 1'h1);
         drive_step(3'h0, 1'h0, 1'h1);
      end
      complete_run;
   end

endmodule
